// >>> verilog/hvpp_map.svh
// Purpose: constants of the parallel high-voltage programming port
// Assumes: 20 MHz clock; flash 8K words, 64-word pages; EEPROM 512 bytes, 4-byte pages
// Notes:   times in microseconds, cycle counts derived in the modules
`ifndef HVPP_MAP_SVH
`define HVPP_MAP_SVH
`define HVPP_CLK_MHZ      20
`define HVPP_T_SIG_US     10
`define HVPP_T_FLASH_US   2600
`define HVPP_T_EE_US      3600
`define HVPP_T_ERASE_US   10500
`define HVPP_T_FUSE_US    4500
`define HVPP_ACT_ADDR     2'h0
`define HVPP_ACT_DATA     2'h1
`define HVPP_ACT_CMD      2'h2
`define HVPP_CMD_NOP      8'h00
`define HVPP_CMD_ERASE    8'h80
`define HVPP_CMD_WFUSE    8'h40
`define HVPP_CMD_WLOCK    8'h20
`define HVPP_CMD_WFLASH   8'h10
`define HVPP_CMD_WEE      8'h11
`define HVPP_CMD_RSIG     8'h08
`define HVPP_CMD_RFUSE    8'h04
`define HVPP_CMD_RFLASH   8'h02
`define HVPP_CMD_REE      8'h03
`define HVPP_FLASH_WORDS  14'h2000
`define HVPP_EE_BYTES     14'h0200
`define HVPP_FPAGE_WORDS  14'h0040
`define HVPP_EPAGE_BYTES  14'h0004
`define HVPP_KEEP_EE_BIT  3
`define HVPP_FUSE_LO_INIT 8'h62
`define HVPP_FUSE_HI_INIT 8'hdf
`define HVPP_FUSE_EX_INIT 8'hf9
`define HVPP_SYNC_INIT    18'h00300
`endif

// >>> verilog/hvpp_pkg.sv
// Purpose: types of the parallel high-voltage programming port
// Assumes: nothing
// Notes:   none
package hvpp_pkg;
  typedef enum logic [1:0] {HV_OFF, HV_SIG, HV_REJECT, HV_PROG} hvpp_state_t;
  typedef enum logic [2:0] {OP_NONE, OP_FLASH, OP_EE, OP_ERASE, OP_FUSE} hvpp_op_t;
endpackage

// >>> verilog/hvpp_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins asynchronous to clock
// Notes:   output moves only when stages two and three agree
module hvpp_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] st1;
  logic [W-1:0] st2;
  logic [W-1:0] st3;
  logic [W-1:0] next_pinOut;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      next_pinOut[i] = (st2[i] == st3[i]) ? st3[i] : pinOut[i];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st1    <= INIT;
      st2    <= INIT;
      st3    <= INIT;
      pinOut <= INIT;
    end else begin
      st1    <= pinIn;
      st2    <= st1;
      st3    <= st2;
      pinOut <= next_pinOut;
    end
  end
endmodule

// >>> verilog/hvpp_nvm.sv
// Purpose: flash and EEPROM arrays behind the programming port
// Assumes: one write port and one asynchronous read port per array
// Notes:   contents are undefined until the first chip erase
module hvpp_nvm (
  input  wire logic        clock,
  input  wire logic        flWe,
  input  wire logic [12:0] flA,
  input  wire logic [15:0] flWd,
  output logic      [15:0] flRd,
  input  wire logic        eeWe,
  input  wire logic [8:0]  eeA,
  input  wire logic [7:0]  eeWd,
  output logic      [7:0]  eeRd
);
  logic [15:0] flMem [8192];
  logic [7:0]  eeMem [512];

  always_ff @(posedge clock) begin
    if (flWe) begin
      flMem[flA] <= flWd;
    end
    if (eeWe) begin
      eeMem[eeA] <= eeWd;
    end
  end

  assign flRd = flMem[flA];
  assign eeRd = eeMem[eeA];
endmodule

// >>> verilog/hvpp_port.sv
// Purpose: parallel high-voltage programming port, device side
// Assumes: all pins asynchronous to clock; supply and high voltage seen as logic levels
// Notes:   loads ignored while busy; long times are parameters
// Behaviour
// - Entry pins latched 10us after high voltage
// - Reset low or power loss leaves mode
// - Command and address retained across operations
// - Address high byte persists until reloaded
// - Erase clears flash, locks, and EEPROM unless keep-EEPROM fuse programmed; keeps fuses
// - Erase: command 80, then write pulse
// - Action 00, select low loads address low
// - Action 01 loads data low or high
// - Page latch copies data into page buffer
// - Low address bits select word, rest page
// - Action 00, select high loads address high
// - Write pulse programs flash page, busy low
// - Command 00 ends page programming
// - EEPROM page write under command 11
// - Flash read drives low or high byte
// - EEPROM read drives addressed byte
// - Fuse write: 0 programs, selects pick byte
// - Lock write; boot locks frozen by main locks
// - Fuse and lock read by byte selects
// - Signature bytes and calibration byte readable
// - Busy flag low during internal operation
// - Data bus driven only while output enable low
// - Fuses latched on entry; keep-EEPROM acts at once
`include "hvpp_map.svh"
module hvpp_port import hvpp_pkg::*; #(
  parameter int         FLASH_CYC = `HVPP_T_FLASH_US * `HVPP_CLK_MHZ,
  parameter int         EE_CYC    = `HVPP_T_EE_US * `HVPP_CLK_MHZ,
  parameter int         ERASE_CYC = `HVPP_T_ERASE_US * `HVPP_CLK_MHZ,
  parameter int         FUSE_CYC  = `HVPP_T_FUSE_US * `HVPP_CLK_MHZ,
  parameter logic [7:0] SIG0      = 8'h5a,
  parameter logic [7:0] SIG1      = 8'h01,
  parameter logic [7:0] SIG2      = 8'h02,
  parameter logic [7:0] CALIB     = 8'h80
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       hvReset,
  input  wire logic       powerGood,
  input  wire logic       pageLatchStrobe,
  input  wire logic       actionCodeHi,
  input  wire logic       actionCodeLo,
  input  wire logic       byteSelectA,
  input  wire logic       byteSelectB,
  input  wire logic       loadStrobe,
  input  wire logic       programStrobeN,
  input  wire logic       outputDriveN,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOen,
  output logic            readyBusyFlag,
  output logic            progMode,
  output logic      [7:0] activeFuseLo,
  output logic      [7:0] activeFuseHi,
  output logic      [7:0] activeFuseExt
);
  localparam logic [7:0] SIG_CYC = 8'(`HVPP_T_SIG_US * `HVPP_CLK_MHZ);

  logic [17:0] syncOut;
  logic sHv, sPwr, sPl, sAh, sAl, sBsA, sBsB, sLd, sWrN, sOeN;
  logic [7:0] sDin;
  hvpp_sync #(.W(18), .INIT(`HVPP_SYNC_INIT)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pinIn   ({hvReset, powerGood, pageLatchStrobe, actionCodeHi, actionCodeLo,
               byteSelectA, byteSelectB, loadStrobe, programStrobeN, outputDriveN, dataIn}),
    .pinOut  (syncOut)
  );
  assign {sHv, sPwr, sPl, sAh, sAl, sBsA, sBsB, sLd, sWrN, sOeN, sDin} = syncOut;

  hvpp_state_t state, next_state;
  hvpp_op_t    op, next_op;
  logic [7:0]  sigCnt, next_sigCnt, cmd, next_cmd;
  logic [7:0]  addrLo, next_addrLo, addrHi, next_addrHi;
  logic [7:0]  dataLo, next_dataLo, dataHi, next_dataHi;
  logic [7:0]  fuseLo, next_fuseLo, fuseHi, next_fuseHi, fuseExt, next_fuseExt;
  logic [7:0]  lockBits, next_lockBits;
  logic [7:0]  next_actLo, next_actHi, next_actExt, next_dataOut;
  logic [23:0] busyCnt, next_busyCnt;
  logic [13:0] walk, next_walk;
  logic        ldPrev, plPrev, wrPrev, next_dataOen;
  logic        ldRise, plRise, wrFall, idle, keepEe;
  logic [15:0] flBuf [64];
  logic [7:0]  eeBuf [4];
  logic        flWe, eeWe, bufFlWe, bufEeWe;
  logic [12:0] flA;
  logic [8:0]  eeA;
  logic [15:0] flWd, flRd;
  logic [7:0]  eeWd, eeRd, rdByte;

  assign ldRise = sLd && !ldPrev;
  assign plRise = sPl && !plPrev;
  assign wrFall = !sWrN && wrPrev;
  assign idle   = (state == HV_PROG) && (op == OP_NONE);
  assign keepEe = !fuseHi[`HVPP_KEEP_EE_BIT];
  assign readyBusyFlag = idle;
  assign progMode = (state == HV_PROG);

  hvpp_nvm u_nvm (
    .clock (clock),
    .flWe  (flWe),
    .flA   (flA),
    .flWd  (flWd),
    .flRd  (flRd),
    .eeWe  (eeWe),
    .eeA   (eeA),
    .eeWd  (eeWd),
    .eeRd  (eeRd)
  );

  function automatic logic walkLive(input logic [13:0] w, input logic [13:0] lim);
    return w < lim;
  endfunction

  // Array ports: walking index during flash, EEPROM and erase operations, programmed address otherwise
  always_comb begin
    flWe = 1'b0;
    eeWe = 1'b0;
    flA  = {addrHi[4:0], addrLo};
    eeA  = {addrHi[0], addrLo};
    flWd = flBuf[walk[5:0]];
    eeWd = eeBuf[walk[1:0]];
    case (op)
      OP_FLASH: begin
        flA  = {addrHi[4:0], addrLo[7:6], walk[5:0]};
        flWe = walkLive(walk, `HVPP_FPAGE_WORDS);
      end
      OP_EE: begin
        eeA  = {addrHi[0], addrLo[7:2], walk[1:0]};
        eeWe = walkLive(walk, `HVPP_EPAGE_BYTES);
      end
      OP_ERASE: begin
        flA  = walk[12:0];
        eeA  = walk[8:0];
        flWd = 16'hffff;
        eeWd = 8'hff;
        flWe = walkLive(walk, `HVPP_FLASH_WORDS);
        eeWe = walkLive(walk, `HVPP_EE_BYTES) && !keepEe;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    next_state = state;    next_op = op;          next_sigCnt = sigCnt;
    next_cmd = cmd;        next_addrLo = addrLo;  next_addrHi = addrHi;
    next_dataLo = dataLo;  next_dataHi = dataHi;  next_fuseLo = fuseLo;
    next_fuseHi = fuseHi;  next_fuseExt = fuseExt; next_lockBits = lockBits;
    next_actLo = activeFuseLo; next_actHi = activeFuseHi; next_actExt = activeFuseExt;
    next_busyCnt = busyCnt; next_walk = walk;
    bufFlWe = 1'b0;
    bufEeWe = 1'b0;
    case (state)
      HV_OFF: begin
        next_sigCnt = 8'h00;
        if (sHv && sPwr) begin
          next_state = HV_SIG;
        end
      end
      HV_SIG: begin
        next_sigCnt = sigCnt + 8'h01;
        if (sigCnt == SIG_CYC - 8'h01) begin
          next_state = ({sPl, sAh, sAl, sBsA} == 4'h0) ? HV_PROG : HV_REJECT;
          next_actLo  = fuseLo;
          next_actHi  = fuseHi;
          next_actExt = fuseExt;
          next_cmd    = `HVPP_CMD_NOP;
        end
      end
      HV_PROG: begin
        if (op != OP_NONE) begin
          if (walk < `HVPP_FLASH_WORDS) begin
            next_walk = walk + 14'h0001;
          end
          if (busyCnt != 24'h0) begin
            next_busyCnt = busyCnt - 24'h000001;
          end else if (!flWe && !eeWe) begin
            next_op = OP_NONE;
            if (op == OP_ERASE) begin
              next_lockBits = 8'hff;
            end
          end
        end else begin
          if (ldRise) begin
            case ({sAh, sAl})
              `HVPP_ACT_ADDR: begin
                if (sBsA) next_addrHi = sDin;
                else      next_addrLo = sDin;
              end
              `HVPP_ACT_DATA: begin
                if (sBsA) next_dataHi = sDin;
                else      next_dataLo = sDin;
              end
              `HVPP_ACT_CMD: next_cmd = sDin;
              default: begin
              end
            endcase
          end
          if (plRise) begin
            bufFlWe = (cmd == `HVPP_CMD_WFLASH);
            bufEeWe = (cmd == `HVPP_CMD_WEE);
          end
          if (wrFall) begin
            next_walk = 14'h0000;
            case (cmd)
              `HVPP_CMD_ERASE: begin
                next_op = OP_ERASE;
                next_busyCnt = 24'(ERASE_CYC);
              end
              `HVPP_CMD_WFLASH: begin
                next_op = OP_FLASH;
                next_busyCnt = 24'(FLASH_CYC);
              end
              `HVPP_CMD_WEE: begin
                if (!sBsA) begin
                  next_op = OP_EE;
                  next_busyCnt = 24'(EE_CYC);
                end
              end
              `HVPP_CMD_WFUSE: begin
                next_op = OP_FUSE;
                next_busyCnt = 24'(FUSE_CYC);
                if (lockBits[0]) begin
                  case ({sBsA, sBsB})
                    2'b00: next_fuseLo = dataLo;
                    2'b10: next_fuseHi = dataLo;
                    2'b01: next_fuseExt = dataLo;
                    default: begin
                    end
                  endcase
                end
              end
              `HVPP_CMD_WLOCK: begin
                next_op = OP_FUSE;
                next_busyCnt = 24'(FUSE_CYC);
                next_lockBits = lockBits & dataLo;
                if (lockBits[1:0] == 2'b00) begin
                  next_lockBits[5:2] = lockBits[5:2];
                end
              end
              default: begin
              end
            endcase
          end
        end
      end
      default: begin
      end
    endcase
    if (!sHv || !sPwr) begin
      next_state = HV_OFF;
      next_op = OP_NONE;
    end
  end

  // Read path; bus only turned round while in mode and output enable low
  always_comb begin
    rdByte = 8'hff;
    case (cmd)
      `HVPP_CMD_RFLASH: rdByte = sBsA ? flRd[15:8] : flRd[7:0];
      `HVPP_CMD_REE: rdByte = sBsA ? 8'hff : eeRd;
      `HVPP_CMD_RFUSE: begin
        case ({sBsB, sBsA})
          2'b00: rdByte = fuseLo;
          2'b11: rdByte = fuseHi;
          2'b10: rdByte = fuseExt;
          default: rdByte = lockBits;
        endcase
      end
      `HVPP_CMD_RSIG: begin
        if (sBsA) rdByte = (addrLo == 8'h00) ? CALIB : 8'hff;
        else if (addrLo == 8'h00) rdByte = SIG0;
        else if (addrLo == 8'h01) rdByte = SIG1;
        else if (addrLo == 8'h02) rdByte = SIG2;
      end
      default: begin
      end
    endcase
    next_dataOut = rdByte;
    next_dataOen = !(progMode && !sOeN);
  end

  always_ff @(posedge clock) begin
    if (bufFlWe) flBuf[addrLo[5:0]] <= {dataHi, dataLo};
    if (bufEeWe) eeBuf[addrLo[1:0]] <= dataLo;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= HV_OFF;        op <= OP_NONE;       sigCnt <= 8'h00;
      cmd <= `HVPP_CMD_NOP;   addrLo <= 8'h00;     addrHi <= 8'h00;
      dataLo <= 8'hff;        dataHi <= 8'hff;
      fuseLo <= `HVPP_FUSE_LO_INIT;  fuseHi <= `HVPP_FUSE_HI_INIT;
      fuseExt <= `HVPP_FUSE_EX_INIT; lockBits <= 8'hff;
      activeFuseLo <= `HVPP_FUSE_LO_INIT; activeFuseHi <= `HVPP_FUSE_HI_INIT;
      activeFuseExt <= `HVPP_FUSE_EX_INIT;
      busyCnt <= 24'h0;       walk <= 14'h0;
      ldPrev <= 1'b0;         plPrev <= 1'b0;      wrPrev <= 1'b1;
      dataOut <= 8'hff;       dataOen <= 1'b1;
    end else begin
      state <= next_state;    op <= next_op;       sigCnt <= next_sigCnt;
      cmd <= next_cmd;        addrLo <= next_addrLo; addrHi <= next_addrHi;
      dataLo <= next_dataLo;  dataHi <= next_dataHi;
      fuseLo <= next_fuseLo;  fuseHi <= next_fuseHi;
      fuseExt <= next_fuseExt; lockBits <= next_lockBits;
      activeFuseLo <= next_actLo; activeFuseHi <= next_actHi;
      activeFuseExt <= next_actExt;
      busyCnt <= next_busyCnt; walk <= next_walk;
      ldPrev <= sLd;          plPrev <= sPl;       wrPrev <= sWrN;
      dataOut <= next_dataOut; dataOen <= next_dataOen;
    end
  end

  chk_exit_mode: assert property (@(posedge clock) disable iff (sys_rst)
    !sHv |=> state == HV_OFF) else $error("mode kept after reset pin low");
  chk_busy_low: assert property (@(posedge clock) disable iff (sys_rst)
    (flWe || eeWe) |-> !readyBusyFlag) else $error("ready while busy");
  chk_bus_drive: assert property (@(posedge clock) disable iff (sys_rst)
    !dataOen |-> $past(progMode && !sOeN)) else $error("bus driven without enable");
  chk_cmd_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (idle && !(ldRise && {sAh, sAl} == 2'b10) && sHv && sPwr) |=> $stable(cmd))
    else $error("command lost");
  chk_addr_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (state == HV_PROG && !(ldRise && {sAh, sAl, sBsA} == 3'b001)) |=> $stable(addrHi))
    else $error("address high changed");
  chk_erase_lock: assert property (@(posedge clock) disable iff (sys_rst)
    ($past(op) == OP_ERASE && op == OP_NONE && progMode) |-> lockBits == 8'hff)
    else $error("locks kept after erase");
  chk_flash_start: assert property (@(posedge clock) disable iff (sys_rst)
    (idle && wrFall && cmd == `HVPP_CMD_WFLASH && sHv && sPwr) |=> op == OP_FLASH [*3])
    else $error("flash write not started");
  chk_data_load: assert property (@(posedge clock) disable iff (sys_rst)
    (idle && ldRise && {sAh, sAl, sBsA} == 3'b010 && sHv && sPwr) |=> dataLo == $past(sDin))
    else $error("data low not loaded");
  chk_boot_lock: assert property (@(posedge clock) disable iff (sys_rst)
    (lockBits[1:0] == 2'b00 && op != OP_ERASE) |=> $stable(lockBits[5:2]))
    else $error("boot locks changed");
  chk_entry_sig: assert property (@(posedge clock) disable iff (sys_rst)
    (state == HV_SIG && sigCnt == SIG_CYC - 8'h01 && {sPl, sAh, sAl, sBsA} != 4'h0)
    |=> state != HV_PROG) else $error("entered with wrong signature");

  cov_entry: cover property (@(posedge clock) disable iff (sys_rst)
    state == HV_SIG ##1 state == HV_PROG);
  cov_erase_done: cover property (@(posedge clock) disable iff (sys_rst)
    op == OP_ERASE ##1 op == OP_NONE);
  cov_flash_page: cover property (@(posedge clock) disable iff (sys_rst)
    op == OP_FLASH ##1 op == OP_NONE);
  cov_fuse_read: cover property (@(posedge clock) disable iff (sys_rst)
    !dataOen && cmd == `HVPP_CMD_RFUSE);
endmodule

// >>> sim/hvpp_programmer.sv
// Purpose: behavioural parallel programmer on the far side of the port pins
// Assumes: pins change just after a rising clock edge, held for several clocks
// Notes:   a released bus shows the inverse of its last byte, there is no pull-up
module hvpp_programmer (
  input  wire logic       clock,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOen,
  input  wire logic       readyBusyFlag,
  output logic            hvReset,
  output logic            powerGood,
  output logic            pageLatchStrobe,
  output logic            actionCodeHi,
  output logic            actionCodeLo,
  output logic            byteSelectA,
  output logic            byteSelectB,
  output logic            loadStrobe,
  output logic            programStrobeN,
  output logic            outputDriveN,
  output logic      [7:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] drv;
  logic       drvOn;
  // Wire level from both parties: the device wins only while it enables its driver
  assign dataIn = !dataOen ? dataOut : (drvOn ? drv : ~drv);
  initial begin
    {hvReset, powerGood, pageLatchStrobe, actionCodeHi, actionCodeLo} = '0;
    {byteSelectA, byteSelectB, loadStrobe, drvOn} = '0;
    {programStrobeN, outputDriveN} = 2'h3;
    drv = 8'h00;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic waitReady(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 12000 && !ok; i++) begin
      @(posedge clock);
      ok = (readyBusyFlag === 1'b1);
    end
  endtask
  task automatic enter();
    powerGood <= 1'b1;
    idle(2);
    hvReset <= 1'b1;
    idle(300);
    idle(5800);
  endtask
  task automatic leave();
    {hvReset, powerGood, pageLatchStrobe, actionCodeHi, actionCodeLo} <= '0;
    byteSelectA <= 1'b0;
    idle(10);
  endtask
  task automatic load(input logic [1:0] act, input logic a, input logic [7:0] d);
    bit ok;
    waitReady(ok);
    {actionCodeHi, actionCodeLo} <= act;
    byteSelectA <= a;
    drv <= d;
    drvOn <= 1'b1;
    idle(6);
    loadStrobe <= 1'b1;
    idle(6);
    loadStrobe <= 1'b0;
    idle(6);
  endtask
  task automatic latch();
    pageLatchStrobe <= 1'b1;
    idle(6);
    pageLatchStrobe <= 1'b0;
    idle(6);
  endtask
  task automatic prog(input logic a, input logic b, output logic busy, output bit ok);
    byteSelectA <= a;
    byteSelectB <= b;
    idle(6);
    programStrobeN <= 1'b0;
    idle(6);
    programStrobeN <= 1'b1;
    idle(4);
    busy = readyBusyFlag;
    waitReady(ok);
  endtask
  task automatic read(input logic a, input logic b, output logic [7:0] v, output logic oen);
    byteSelectA <= a;
    byteSelectB <= b;
    drvOn <= 1'b0;
    outputDriveN <= 1'b0;
    idle(8);
    v = dataOut;
    oen = dataOen;
    outputDriveN <= 1'b1;
    idle(6);
  endtask
endmodule

// >>> sim/tb_hvpp_port.sv
// Purpose: self-checking bench of the programming port
// Assumes: short busy counts; erase still walks the whole flash
// Notes:   reads are table rows; writes, locks and mode exit are hand-written
module tb_hvpp_port;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] cmd; logic [7:0] hi; logic [7:0] lo; logic a; logic b;
                  logic [7:0] exp;} hvpp_row_t;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       hvReset, powerGood, pageLatchStrobe, actionCodeHi, actionCodeLo;
  logic       byteSelectA, byteSelectB, loadStrobe, programStrobeN, outputDriveN;
  logic [7:0] dataIn, dataOut, activeFuseLo, activeFuseHi, activeFuseExt;
  logic       dataOen, readyBusyFlag, progMode;
  int         n_fail = 0;
  int         n_compared = 0;
  int         cycles = 0;
  logic [7:0] rdV;
  logic       rdOen;
  hvpp_row_t  rows [14] = '{'{8'h02, 8'h01, 8'h40, 0, 0, 8'h30}, '{8'h02, 8'h01, 8'h40, 1, 0, 8'ha0},
    '{8'h02, 8'h01, 8'h41, 0, 0, 8'h31}, '{8'h02, 8'h01, 8'h41, 1, 0, 8'ha1},
    '{8'h02, 8'h01, 8'h80, 0, 0, 8'hff}, '{8'h03, 8'h01, 8'h05, 0, 0, 8'h3c},
    '{8'h04, 8'h00, 8'h00, 0, 0, 8'h62}, '{8'h04, 8'h00, 8'h00, 1, 1, 8'hdf},
    '{8'h04, 8'h00, 8'h00, 0, 1, 8'hf9}, '{8'h04, 8'h00, 8'h00, 1, 0, 8'hff},
    '{8'h08, 8'h00, 8'h00, 0, 0, 8'h5a}, '{8'h08, 8'h00, 8'h01, 0, 0, 8'h01},
    '{8'h08, 8'h00, 8'h02, 0, 0, 8'h02}, '{8'h08, 8'h00, 8'h00, 1, 0, 8'h80}};
  always #25 clock = ~clock;
  hvpp_port #(.FLASH_CYC(16), .EE_CYC(16), .ERASE_CYC(16), .FUSE_CYC(16)) u_dut (
    .clock, .sys_rst, .hvReset, .powerGood, .pageLatchStrobe, .actionCodeHi,
    .actionCodeLo, .byteSelectA, .byteSelectB, .loadStrobe, .programStrobeN,
    .outputDriveN, .dataIn, .dataOut, .dataOen, .readyBusyFlag, .progMode,
    .activeFuseLo, .activeFuseHi, .activeFuseExt);
  hvpp_programmer u_prog (
    .clock, .dataOut, .dataOen, .readyBusyFlag, .hvReset, .powerGood, .pageLatchStrobe,
    .actionCodeHi, .actionCodeLo, .byteSelectA, .byteSelectB, .loadStrobe,
    .programStrobeN, .outputDriveN, .dataIn);
  task automatic cmpByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpBit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Busy must be seen low shortly after the strobe and clear within the bound
  task automatic progChk(input logic a, input logic b);
    logic busy;
    bit   ok;
    u_prog.prog(a, b, busy, ok);
    cmpBit("readyBusyFlag busy", 1'b0, busy);
    cmpBit("readyBusyFlag ready", 1'b1, ok);
  endtask
  task automatic checkRead(input hvpp_row_t r);
    logic [7:0] v;
    logic       oen;
    u_prog.load(2'h2, 1'b0, r.cmd);
    u_prog.load(2'h0, 1'b1, r.hi);
    u_prog.load(2'h0, 1'b0, r.lo);
    u_prog.read(r.a, r.b, v, oen);
    cmpBit("dataOen", 1'b0, oen);
    cmpByte("dataOut", r.exp, v);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    cmpBit("progMode", 1'b0, progMode);
    cmpBit("readyBusyFlag", 1'b0, readyBusyFlag);
    cmpBit("dataOen", 1'b1, dataOen);
    cmpByte("activeFuseLo", 8'h62, activeFuseLo);
    cmpByte("activeFuseHi", 8'hdf, activeFuseHi);
    cmpByte("activeFuseExt", 8'hf9, activeFuseExt);
    @(posedge clock);
    sys_rst <= 1'b0;
    $display("test reset done");
    u_prog.enter();
    cmpBit("progMode", 1'b1, progMode);
    u_prog.load(2'h2, 1'b0, 8'h80);
    progChk(1'b0, 1'b0);
    u_prog.load(2'h2, 1'b0, 8'h10);
    u_prog.load(2'h0, 1'b1, 8'h01);
    for (int w = 0; w < 2; w++) begin
      u_prog.load(2'h0, 1'b0, 8'h40 + 8'(w));
      u_prog.load(2'h1, 1'b0, 8'h30 + 8'(w));
      u_prog.load(2'h1, 1'b1, 8'ha0 + 8'(w));
      u_prog.latch();
    end
    progChk(1'b0, 1'b0);
    u_prog.load(2'h2, 1'b0, 8'h00);
    u_prog.load(2'h2, 1'b0, 8'h11);
    u_prog.load(2'h0, 1'b0, 8'h05);
    u_prog.load(2'h1, 1'b0, 8'h3c);
    u_prog.latch();
    progChk(1'b0, 1'b0);
    $display("test writes done");
    foreach (rows[i]) checkRead(rows[i]);
    cmpBit("dataOen released", 1'b1, dataOen);
    $display("test reads done");
    u_prog.load(2'h2, 1'b0, 8'h02);
    u_prog.load(2'h0, 1'b1, 8'h01);
    u_prog.load(2'h0, 1'b0, 8'h40);
    // A stray action 11 must neither become the command nor move the address
    u_prog.load(2'h3, 1'b0, 8'h04);
    u_prog.read(1'b0, 1'b0, rdV, rdOen);
    cmpByte("dataOut idle action", 8'h30, rdV);
    u_prog.load(2'h2, 1'b0, 8'h40);
    u_prog.load(2'h1, 1'b0, 8'ha5);
    progChk(1'b1, 1'b0);
    cmpByte("activeFuseHi", 8'hdf, activeFuseHi);
    checkRead('{8'h04, 8'h00, 8'h00, 1, 1, 8'ha5});
    u_prog.load(2'h2, 1'b0, 8'h20);
    u_prog.load(2'h1, 1'b0, 8'hfc);
    progChk(1'b0, 1'b0);
    u_prog.load(2'h1, 1'b0, 8'hc3);
    progChk(1'b0, 1'b0);
    checkRead('{8'h04, 8'h00, 8'h00, 1, 0, 8'hfc});
    $display("test fuse and lock done");
    u_prog.load(2'h2, 1'b0, 8'h80);
    progChk(1'b0, 1'b0);
    checkRead('{8'h04, 8'h00, 8'h00, 1, 0, 8'hff});
    checkRead('{8'h04, 8'h00, 8'h00, 1, 1, 8'ha5});
    checkRead('{8'h02, 8'h01, 8'h40, 0, 0, 8'hff});
    checkRead('{8'h03, 8'h01, 8'h05, 0, 0, 8'h3c});
    $display("test second erase done");
    u_prog.leave();
    cmpBit("progMode", 1'b0, progMode);
    u_prog.enter();
    cmpByte("activeFuseHi", 8'ha5, activeFuseHi);
    $display("test reentry done");
    u_prog.leave();
    // Wrong entry pattern: the device must stay out of the mode
    u_prog.actionCodeLo <= 1'b1;
    u_prog.powerGood <= 1'b1;
    u_prog.hvReset <= 1'b1;
    u_prog.idle(300);
    cmpBit("progMode bad entry", 1'b0, progMode);
    cmpBit("readyBusyFlag bad entry", 1'b0, readyBusyFlag);
    $display("test rejected entry done");
    tally_and_finish();
  end
endmodule
